// ===== wdp_pkg.sv
// Constants for the watchdog, periodic timer and stop wake-up clock sequencer.
// Assumes a single AHB-Lite slave port on the gated oscillator clock domain.
//
// What this block does
// - Unserviced enabled watchdog timeout causes system reset.
// - Three-bit field selects seven watchdog periods.
// - Write 0x55 then 0xaa restarts watchdog.
// - Other service value resets device immediately.
// - Window mode: early service write resets device.
// - Watchdog runs in pseudo stop when enabled.
// - Both timers run from gated oscillator clock.
// - Periodic period end sets flag, restarts immediately.
// - Enabled periodic flag raises interrupt request.
// - Rate control write restarts periodic period.
// - Periodic timer runs in pseudo stop when enabled.
// - Full stop left only by interrupt or reset.
// - Reset in stop: defaults, checks, then reset.
// - Slow interrupt wake: check, then release clocks.
// - All wake-up checks fail: self-clock or monitor reset.
// - Fast wake resumes self-clock, oscillator off, no flag.
// - Clearing fast wake checks, switches, sets flag.
// - Leaving full stop clears PLL select.
// - Full stop and fast self-clock disable monitor, oscillator.
// - Clock check enables PLL and regulator.
// - Quality checking continues during fallback handling.
// - Clock monitor reset forces self-clock enable.
package wdp_pkg;
	// Register byte offsets.
	localparam logic [7:0] WDP_OFS_WDT_CTRL = 8'h00;
	localparam logic [7:0] WDP_OFS_WDT_SERVICE = 8'h04;
	localparam logic [7:0] WDP_OFS_PIT_RATE = 8'h08;
	localparam logic [7:0] WDP_OFS_PIT_IRQ = 8'h0c;
	localparam logic [7:0] WDP_OFS_CLK_CTRL = 8'h10;
	localparam logic [7:0] WDP_OFS_STATUS = 8'h14;
	// Field positions.
	localparam int WDP_WCTL_RATE_LSB = 0;
	localparam int WDP_WCTL_PSTOP_BIT = 6;
	localparam int WDP_WCTL_WINDOW_BIT = 7;
	localparam int WDP_IRQ_EN_BIT = 0;
	localparam int WDP_IRQ_FLAG_BIT = 8;
	localparam int WDP_CLK_FWE_BIT = 0;
	localparam int WDP_CLK_SELF_CLOCK_MODE_ENABLE_BIT = 1;
	localparam int WDP_CLK_PLL_CLOCK_SELECT_BIT = 2;
	localparam int WDP_CLK_PSTOPSEL_BIT = 3;
	localparam int WDP_CLK_PITPSTOP_BIT = 4;
	localparam int WDP_STAT_SCF_BIT = 0;
	localparam int WDP_STAT_STATE_LSB = 8;
	// Service codes.
	localparam logic [7:0] WDP_SVC_FIRST = 8'h55;
	localparam logic [7:0] WDP_SVC_SECOND = 8'haa;
	// Reset values.
	localparam logic [2:0] WDP_WDT_RATE_RST = 3'h0;
	localparam logic [3:0] WDP_PIT_RATE_RST = 4'h0;
	localparam logic WDP_SELF_CLOCK_MODE_ENABLE_RST = 1'b1;
	// Most clock check windows before the timeout is declared.
	localparam logic [5:0] WDP_CHECK_WINDOWS = 6'h32;
	// Counter width of both timers; wide enough for the longest periodic rate
	// at the default base, so no limit wraps to zero.
	localparam int WDP_CNT_W = 26;
	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		WDP_ST_RUN = 7'h01,
		WDP_ST_PSTOP = 7'h02,
		WDP_ST_FSTOP = 7'h04,
		WDP_ST_CHK_RST = 7'h08,
		WDP_ST_CHK_WAKE = 7'h10,
		WDP_ST_SCM = 7'h20,
		WDP_ST_SCM_FAST = 7'h40
	} wdp_state_t;
endpackage

// ===== wdp_top.sv
// Watchdog, periodic interrupt timer and stop wake-up clock sequencer.
// Assumes hclk is the gated oscillator clock and the quality checker, PLL and
// regulator sit outside, reached only through the check ports below.
`timescale 1ns/1ps
`default_nettype none
module wdp_top #(
	parameter int WDT_BASE_LOG2 = 14,
	parameter int PIT_BASE_LOG2 = 10
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Core mode requests and wake source.
	input wire logic stop_req,
	input wire logic wake_irq_pin,
	// Clock quality checker.
	input wire logic qc_window_done,
	input wire logic qc_pass,
	output logic qc_active,
	output logic pll_voltage_regulator_unit_enable,
	// Clock controls.
	output logic osc_enable,
	output logic clk_monitor_enable,
	output logic self_clock_active,
	output logic sys_clk_release,
	output logic pll_clock_select,
	// Resets and interrupt.
	output logic core_reset_hold,
	output logic watchdog_reset,
	output logic clock_monitor_reset,
	output logic periodic_irq
);
	wdp_pkg::wdp_state_t state_r;
	wdp_pkg::wdp_state_t state_nxt;
	logic addr_wr_r;
	logic [7:0] addr_r;
	logic bus_wr;
	logic [2:0] wdt_rate_r;
	logic wdt_window_r;
	logic wdt_pstop_run_r;
	logic [3:0] pit_rate_r;
	logic pit_irq_en_r;
	logic pit_flag_r;
	logic fast_wakeup_enable_r;
	logic self_clock_mode_enable_r;
	logic pll_clock_select_r;
	logic pseudo_stop_select_r;
	logic pit_pstop_run_r;
	logic self_clock_flag_r;
	logic [wdp_pkg::WDP_CNT_W-1:0] wdt_cnt_r;
	logic [wdp_pkg::WDP_CNT_W-1:0] wdt_limit;
	logic [wdp_pkg::WDP_CNT_W-1:0] pit_cnt_r;
	logic [wdp_pkg::WDP_CNT_W-1:0] pit_limit;
	logic wdt_armed_r;
	logic wdt_run;
	logic pit_run;
	logic svc_wr;
	logic svc_bad;
	logic svc_done;
	logic pit_end;
	logic [2:0] wake_sync_r;
	logic wake_lvl_r;
	logic [5:0] win_cnt_r;
	logic chk_fail;
	logic cm_event;
	logic enter_scm;
	logic leave_stop;

	// Bus writes land in the data phase after an accepted address phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_wr_r <= 1'b0;
			addr_r <= 8'h00;
		end else if (hready) begin
			addr_wr_r <= hsel && htrans[1] && hwrite;
			addr_r <= haddr[7:0];
		end
	end
	assign bus_wr = addr_wr_r;

	// Read data is fetched at the address phase so it stands in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			if (hready && hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
				case (haddr[7:0])
					wdp_pkg::WDP_OFS_WDT_CTRL: begin
						hrdata <= {24'h00_0000, wdt_window_r, wdt_pstop_run_r, 3'h0, wdt_rate_r};
					end
					wdp_pkg::WDP_OFS_PIT_RATE: begin
						hrdata <= {28'h000_0000, pit_rate_r};
					end
					wdp_pkg::WDP_OFS_PIT_IRQ: begin
						hrdata <= {23'h00_0000, pit_flag_r, 7'h00, pit_irq_en_r};
					end
					wdp_pkg::WDP_OFS_CLK_CTRL: begin
						hrdata <= {27'h000_0000, pit_pstop_run_r, pseudo_stop_select_r,
							pll_clock_select_r, self_clock_mode_enable_r, fast_wakeup_enable_r};
					end
					wdp_pkg::WDP_OFS_STATUS: begin
						hrdata <= {17'h0_0000, state_r, 7'h00, self_clock_flag_r};
					end
					default: begin
						hrdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Watchdog and periodic timer configuration; reset restores defaults at once.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_rate_r <= wdp_pkg::WDP_WDT_RATE_RST;
			wdt_window_r <= 1'b0;
			wdt_pstop_run_r <= 1'b0;
			pit_rate_r <= wdp_pkg::WDP_PIT_RATE_RST;
			pit_irq_en_r <= 1'b0;
		end else if (bus_wr) begin
			case (addr_r)
				wdp_pkg::WDP_OFS_WDT_CTRL: begin
					wdt_rate_r <= hwdata[wdp_pkg::WDP_WCTL_RATE_LSB +: 3];
					wdt_window_r <= hwdata[wdp_pkg::WDP_WCTL_WINDOW_BIT];
					wdt_pstop_run_r <= hwdata[wdp_pkg::WDP_WCTL_PSTOP_BIT];
				end
				wdp_pkg::WDP_OFS_PIT_RATE: begin
					pit_rate_r <= hwdata[3:0];
				end
				wdp_pkg::WDP_OFS_PIT_IRQ: begin
					pit_irq_en_r <= hwdata[wdp_pkg::WDP_IRQ_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Clock control bits; hardware events override software writes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_wakeup_enable_r <= 1'b0;
			self_clock_mode_enable_r <= wdp_pkg::WDP_SELF_CLOCK_MODE_ENABLE_RST;
			pll_clock_select_r <= 1'b0;
			pseudo_stop_select_r <= 1'b0;
			pit_pstop_run_r <= 1'b0;
		end else begin
			if (bus_wr && addr_r == wdp_pkg::WDP_OFS_CLK_CTRL) begin
				fast_wakeup_enable_r <= hwdata[wdp_pkg::WDP_CLK_FWE_BIT];
				self_clock_mode_enable_r <= hwdata[wdp_pkg::WDP_CLK_SELF_CLOCK_MODE_ENABLE_BIT];
				pll_clock_select_r <= hwdata[wdp_pkg::WDP_CLK_PLL_CLOCK_SELECT_BIT];
				pseudo_stop_select_r <= hwdata[wdp_pkg::WDP_CLK_PSTOPSEL_BIT];
				pit_pstop_run_r <= hwdata[wdp_pkg::WDP_CLK_PITPSTOP_BIT];
			end
			if (cm_event) begin
				self_clock_mode_enable_r <= 1'b1;
			end
			if (leave_stop) begin
				pll_clock_select_r <= 1'b0;
			end
		end
	end

	// Each timer counts hclk, the gated oscillator clock, never the PLL clock.
	assign wdt_run = (wdt_rate_r != 3'h0) && (state_r == wdp_pkg::WDP_ST_RUN ||
		state_r == wdp_pkg::WDP_ST_SCM || (state_r == wdp_pkg::WDP_ST_PSTOP &&
		wdt_pstop_run_r));
	assign pit_run = (pit_rate_r != 4'h0) && (state_r == wdp_pkg::WDP_ST_RUN ||
		state_r == wdp_pkg::WDP_ST_SCM || (state_r == wdp_pkg::WDP_ST_PSTOP &&
		pit_pstop_run_r));
	assign wdt_limit = wdp_pkg::WDP_CNT_W'(1) << (WDT_BASE_LOG2 + 32'(wdt_rate_r));
	assign pit_limit = wdp_pkg::WDP_CNT_W'(1) << (PIT_BASE_LOG2 + 32'(pit_rate_r));

	// Service decode; a value other than the two codes, or an early write in
	// window mode, is a fault. Writes while the watchdog is off are ignored.
	assign svc_wr = bus_wr && addr_r == wdp_pkg::WDP_OFS_WDT_SERVICE && wdt_rate_r != 3'h0;
	assign svc_bad = svc_wr && ((hwdata[7:0] != wdp_pkg::WDP_SVC_FIRST &&
		hwdata[7:0] != wdp_pkg::WDP_SVC_SECOND) || (wdt_window_r &&
		wdt_cnt_r < wdt_limit - (wdt_limit >> 2)));
	assign svc_done = svc_wr && !svc_bad && wdt_armed_r &&
		hwdata[7:0] == wdp_pkg::WDP_SVC_SECOND;

	// The first code arms; only the second code as the very next service write completes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_armed_r <= 1'b0;
		end else if (svc_wr) begin
			wdt_armed_r <= !svc_bad && hwdata[7:0] == wdp_pkg::WDP_SVC_FIRST;
		end
	end

	// Watchdog counter and reset request, a one-cycle registered pulse.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_cnt_r <= '0;
			watchdog_reset <= 1'b0;
		end else begin
			watchdog_reset <= svc_bad || (wdt_run && wdt_cnt_r == wdt_limit - 1'b1);
			if (svc_done || svc_bad || wdt_rate_r == 3'h0) begin
				wdt_cnt_r <= '0;
			end else if (wdt_run) begin
				if (wdt_cnt_r == wdt_limit - 1'b1) begin
					wdt_cnt_r <= '0;
				end else begin
					wdt_cnt_r <= wdt_cnt_r + 1'b1;
				end
			end
		end
	end

	// Periodic counter; the period end wraps with no idle cycle in between.
	assign pit_end = pit_run && pit_cnt_r == pit_limit - 1'b1;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pit_cnt_r <= '0;
		end else if (bus_wr && addr_r == wdp_pkg::WDP_OFS_PIT_RATE) begin
			pit_cnt_r <= '0;
		end else if (pit_end) begin
			pit_cnt_r <= '0;
		end else if (pit_run) begin
			pit_cnt_r <= pit_cnt_r + 1'b1;
		end
	end

	// Periodic flag is write-one-to-clear, and a new period end wins the race.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pit_flag_r <= 1'b0;
			periodic_irq <= 1'b0;
		end else begin
			if (pit_end) begin
				pit_flag_r <= 1'b1;
			end else if (bus_wr && addr_r == wdp_pkg::WDP_OFS_PIT_IRQ &&
				hwdata[wdp_pkg::WDP_IRQ_FLAG_BIT]) begin
				pit_flag_r <= 1'b0;
			end
			periodic_irq <= pit_irq_en_r && (pit_flag_r || pit_end);
		end
	end

	// The wake pin is asynchronous: three stages, level taken when two agree.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_sync_r <= 3'h0;
			wake_lvl_r <= 1'b0;
		end else begin
			wake_sync_r <= {wake_sync_r[1:0], wake_irq_pin};
			if (wake_sync_r[1] == wake_sync_r[2]) begin
				wake_lvl_r <= wake_sync_r[2];
			end
		end
	end

	// Check windows seen during the current clock quality check.
	assign chk_fail = qc_active && qc_window_done && !qc_pass &&
		win_cnt_r == wdp_pkg::WDP_CHECK_WINDOWS - 6'h01;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_cnt_r <= 6'h00;
		end else if (!qc_active || qc_pass || chk_fail) begin
			win_cnt_r <= 6'h00;
		end else if (qc_window_done) begin
			win_cnt_r <= win_cnt_r + 6'h01;
		end
	end

	// Timeout with fallback off gives a monitor reset; checking carries on.
	assign cm_event = chk_fail && state_r == wdp_pkg::WDP_ST_CHK_WAKE &&
		!self_clock_mode_enable_r;
	assign enter_scm = chk_fail && state_r == wdp_pkg::WDP_ST_CHK_WAKE &&
		self_clock_mode_enable_r;
	assign leave_stop = state_r == wdp_pkg::WDP_ST_FSTOP && wake_lvl_r;

	// Stop entry and wake-up sequencing.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			wdp_pkg::WDP_ST_RUN: begin
				if (stop_req) begin
					state_nxt = pseudo_stop_select_r ? wdp_pkg::WDP_ST_PSTOP : wdp_pkg::WDP_ST_FSTOP;
				end
			end
			wdp_pkg::WDP_ST_PSTOP: begin
				if (wake_lvl_r) begin
					state_nxt = wdp_pkg::WDP_ST_RUN;
				end
			end
			wdp_pkg::WDP_ST_FSTOP: begin
				if (wake_lvl_r) begin
					if (fast_wakeup_enable_r && self_clock_mode_enable_r) begin
						state_nxt = wdp_pkg::WDP_ST_SCM_FAST;
					end else begin
						state_nxt = wdp_pkg::WDP_ST_CHK_WAKE;
					end
				end
			end
			wdp_pkg::WDP_ST_CHK_RST: begin
				if (qc_pass || chk_fail) begin
					state_nxt = wdp_pkg::WDP_ST_RUN;
				end
			end
			wdp_pkg::WDP_ST_CHK_WAKE: begin
				if (qc_pass) begin
					state_nxt = wdp_pkg::WDP_ST_RUN;
				end else if (enter_scm) begin
					state_nxt = wdp_pkg::WDP_ST_SCM;
				end
			end
			wdp_pkg::WDP_ST_SCM: begin
				if (qc_pass) begin
					state_nxt = wdp_pkg::WDP_ST_RUN;
				end
			end
			wdp_pkg::WDP_ST_SCM_FAST: begin
				if (!fast_wakeup_enable_r) begin
					state_nxt = wdp_pkg::WDP_ST_SCM;
				end
			end
			default: begin
				state_nxt = wdp_pkg::WDP_ST_CHK_RST;
			end
		endcase
	end

	// A reset always starts with a clock check before the core is let go.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= wdp_pkg::WDP_ST_CHK_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Self-clock flag: set on fallback entry or on the switch back after a
	// fast wake, never on the fast wake itself; write one clears, set wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			self_clock_flag_r <= 1'b0;
		end else if (enter_scm || (state_r == wdp_pkg::WDP_ST_SCM &&
			qc_pass)) begin
			self_clock_flag_r <= 1'b1;
		end else if (bus_wr && addr_r == wdp_pkg::WDP_OFS_STATUS &&
			hwdata[wdp_pkg::WDP_STAT_SCF_BIT]) begin
			self_clock_flag_r <= 1'b0;
		end
	end

	// Clock control outputs, all registered; the enables are decoded from the next state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			qc_active <= 1'b1;
			pll_voltage_regulator_unit_enable <= 1'b1;
			osc_enable <= 1'b1;
			clk_monitor_enable <= 1'b0;
			self_clock_active <= 1'b0;
			sys_clk_release <= 1'b0;
			core_reset_hold <= 1'b1;
			clock_monitor_reset <= 1'b0;
			pll_clock_select <= 1'b0;
		end else begin
			qc_active <= state_nxt == wdp_pkg::WDP_ST_CHK_RST ||
				state_nxt == wdp_pkg::WDP_ST_CHK_WAKE || state_nxt == wdp_pkg::WDP_ST_SCM;
			pll_voltage_regulator_unit_enable <= state_nxt == wdp_pkg::WDP_ST_CHK_RST ||
				state_nxt == wdp_pkg::WDP_ST_CHK_WAKE || state_nxt == wdp_pkg::WDP_ST_SCM ||
				state_nxt == wdp_pkg::WDP_ST_SCM_FAST;
			osc_enable <= state_nxt != wdp_pkg::WDP_ST_FSTOP &&
				state_nxt != wdp_pkg::WDP_ST_SCM_FAST;
			clk_monitor_enable <= state_nxt == wdp_pkg::WDP_ST_RUN ||
				state_nxt == wdp_pkg::WDP_ST_PSTOP;
			self_clock_active <= state_nxt == wdp_pkg::WDP_ST_SCM ||
				state_nxt == wdp_pkg::WDP_ST_SCM_FAST;
			sys_clk_release <= state_nxt == wdp_pkg::WDP_ST_RUN ||
				state_nxt == wdp_pkg::WDP_ST_SCM || state_nxt == wdp_pkg::WDP_ST_SCM_FAST;
			if (state_r == wdp_pkg::WDP_ST_CHK_RST && state_nxt == wdp_pkg::WDP_ST_RUN) begin
				core_reset_hold <= 1'b0;
			end
			clock_monitor_reset <= cm_event;
			pll_clock_select <= leave_stop ? 1'b0 : pll_clock_select_r;
		end
	end
endmodule
`default_nettype wire

// ===== wdp_props.sv
// Port checker for wdp_top: reset pulses, clock enables and wake-up ordering.
// Assumes it is bound to wdp_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wdp_props (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	// Sequencer.
	input wire logic qc_pass,
	input wire logic qc_active,
	input wire logic pll_voltage_regulator_unit_enable,
	input wire logic osc_enable,
	input wire logic clk_monitor_enable,
	input wire logic sys_clk_release,
	input wire logic core_reset_hold,
	input wire logic watchdog_reset,
	input wire logic clock_monitor_reset
);
	logic svc_r, ctl_r;
	logic [2:0] rate_r;
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Shadow the watchdog rate so a bad code is only judged while the watchdog is enabled.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			svc_r <= 1'b0;
			ctl_r <= 1'b0;
			rate_r <= 3'h0;
		end else if (hreadyout) begin
			if (ctl_r) begin
				rate_r <= hwdata[2:0];
			end
			svc_r <= hsel && htrans[1] && hwrite && haddr[7:0] == wdp_pkg::WDP_OFS_WDT_SERVICE;
			ctl_r <= hsel && htrans[1] && hwrite && haddr[7:0] == wdp_pkg::WDP_OFS_WDT_CTRL;
		end
	end

	property p_wdr_pulse;
		watchdog_reset |=> !watchdog_reset;
	endproperty
	a_wdr_pulse: assert property (p_wdr_pulse) else $error("watchdog reset too long");
	property p_bad_svc;
		svc_r && rate_r != 3'h0 && hwdata[7:0] != wdp_pkg::WDP_SVC_FIRST
			&& hwdata[7:0] != wdp_pkg::WDP_SVC_SECOND |-> ##[1:2] watchdog_reset;
	endproperty
	a_bad_svc: assert property (p_bad_svc) else $error("bad service code kept");
	property p_cmr_pulse;
		clock_monitor_reset |=> !clock_monitor_reset;
	endproperty
	a_cmr_pulse: assert property (p_cmr_pulse) else $error("monitor reset too long");
	property p_cmr_check;
		clock_monitor_reset |-> ##[0:1] qc_active;
	endproperty
	a_cmr_check: assert property (p_cmr_check) else $error("check stopped on reset");
	property p_chk_pll;
		qc_active |-> pll_voltage_regulator_unit_enable;
	endproperty
	a_chk_pll: assert property (p_chk_pll) else $error("check without pll");
	property p_mon_osc;
		!osc_enable |-> !clk_monitor_enable;
	endproperty
	a_mon_osc: assert property (p_mon_osc) else $error("monitor on, osc off");
	property p_hold_rel;
		core_reset_hold && qc_pass |=> !core_reset_hold;
	endproperty
	a_hold_rel: assert property (p_hold_rel) else $error("reset hold kept");
	property p_pass_rel;
		qc_active && qc_pass && !core_reset_hold |-> ##[1:3] sys_clk_release;
	endproperty
	a_pass_rel: assert property (p_pass_rel) else $error("clocks not released");
endmodule
bind wdp_top wdp_props wdp_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hreadyout, .qc_pass, .qc_active, .pll_voltage_regulator_unit_enable, .osc_enable,
	.clk_monitor_enable, .sys_clk_release, .core_reset_hold, .watchdog_reset,
	.clock_monitor_reset);
`default_nettype wire

// ===== watchdog_periodic_irq_stop_wakeup_test.sv
// Bench for wdp_top: bus access, watchdog, periodic timer and stop wake-up.
// Assumes short timer bases; the bench plays core, clock checker and reset source.
`timescale 1ns/1ps
`default_nettype none
module watchdog_periodic_irq_stop_wakeup_test;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic stop_req = 1'b0, wake_irq_pin = 1'b0, qc_window_done = 1'b0, qc_pass = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, qc_active, pll_voltage_regulator_unit_enable, osc_enable, clk_monitor_enable;
	logic self_clock_active, sys_clk_release, pll_clock_select, core_reset_hold;
	logic watchdog_reset, clock_monitor_reset, periodic_irq;
	integer seed = 81;
	int num_errors = 0, num_checks = 0, cyc = 0, wdr_n = 0, cmr_n = 0, n, t, d0, prev;

	// One slave only, so the bus ready is its own ready.
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	// Count one-cycle pulses here so none slips past while a bus task runs.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (watchdog_reset === 1'b1) wdr_n <= wdr_n + 1;
		if (clock_monitor_reset === 1'b1) cmr_n <= cmr_n + 1;
	end

	wdp_top #(.WDT_BASE_LOG2(2), .PIT_BASE_LOG2(2)) wdp_top_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .stop_req, .wake_irq_pin, .qc_window_done,
		.qc_pass, .qc_active, .pll_voltage_regulator_unit_enable, .osc_enable, .clk_monitor_enable,
		.self_clock_active, .sys_clk_release, .pll_clock_select, .core_reset_hold,
		.watchdog_reset, .clock_monitor_reset, .periodic_irq
	);

	task automatic stop_test;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return periodic_irq;
			1: return watchdog_reset;
			2: return qc_active;
			3: return self_clock_active;
			default: return sys_clk_release;
		endcase
	endfunction

	// Bounded wait; running out ends the run as a failure.
	task automatic wait_for(input int w, input int lim);
		n = 0;
		while (sig(w) !== 1'b1) begin
			@(posedge hclk);
			#1;
			n++;
			if (n > lim) begin
				num_errors++;
				$display("Error wait %0d expected 1 seen 0", w);
				stop_test();
			end
		end
	endtask

	// One single word transfer; holds each phase until ready is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int k = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dat;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 40);
		rd = hrdata;
		chk("hresp", 0, hresp);
		chk("bus_wait", 1, k < 40);
		if (k >= 40) stop_test();
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		bus(1'b1, a, dat);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("read", e, rd);
	endtask

	// Clears the periodic flag with the enable kept on.
	task automatic clr;
		wr(8'h0c, 32'h101);
		@(posedge hclk);
		#1;
		chk("irq_clr", 0, periodic_irq);
	endtask

	// Pulses window done, pass or stop; holds wake long enough for its synchroniser.
	task automatic pulse(input int w);
		qc_window_done <= (w == 0);
		qc_pass <= (w == 1);
		stop_req <= (w == 2);
		wake_irq_pin <= (w == 3);
		repeat ((w == 3) ? 6 : 1) @(posedge hclk);
		#1;
		qc_window_done <= 1'b0;
		qc_pass <= 1'b0;
		stop_req <= 1'b0;
		wake_irq_pin <= 1'b0;
		@(posedge hclk);
		#1;
	endtask

	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		chk("rst", 32'hf, {hreadyout, qc_active, pll_voltage_regulator_unit_enable, osc_enable, core_reset_hold});
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		pulse(1);
		chk("hold", 0, core_reset_hold);
	endtask

	// Main sequence: timer, watchdog, then the three wake-up paths.
	initial begin
		do_reset();
		rdc(8'h10, 32'h2);
		rdc(8'h20, 32'h0);
		wr(8'h0c, 32'h1);
		for (int r = 2; r <= 4; r++) begin
			clr();
			t = cyc;
			wr(8'h08, r);
			wait_for(0, 300);
			d0 = cyc - t;
			t = cyc;
			clr();
			wait_for(0, 300);
			chk("pit_period", 1 << (2 + r), cyc - t);
			clr();
			repeat ($unsigned($random(seed)) % 4) @(posedge hclk);
			#1;
			t = cyc;
			wr(8'h08, r);
			wait_for(0, 300);
			chk("pit_restart", d0, cyc - t);
		end
		wr(8'h0c, 32'h100);
		repeat (80) @(posedge hclk);
		#1;
		chk("irq_off", 0, periodic_irq);
		rdc(8'h0c, 32'h100);
		for (int r = 1; r <= 7; r++) begin
			do_reset();
			t = cyc;
			wr(8'h00, r);
			wait_for(1, 700);
			if (r > 1) chk("wdt_period", 1 << (1 + r), cyc - t - prev);
			prev = cyc - t;
		end
		do_reset();
		wr(8'h00, 32'h3);
		d0 = wdr_n;
		repeat (4) begin
			repeat (16) @(posedge hclk);
			#1;
			wr(8'h04, 32'h55);
			wr(8'h04, 32'haa);
		end
		chk("wdt_kept", d0, wdr_n);
		// Bad code, interleaved code, and an early write in window mode.
		for (int i = 0; i < 4; i++) begin
			do_reset();
			wr(8'h00, (i == 3) ? 32'h84 : 32'h3);
			t = $random(seed) & 32'hff;
			if (t == 32'h55 || t == 32'haa) t = 32'h12;
			if (i > 0) wr(8'h04, 32'h55);
			if (i < 3) wr(8'h04, t);
			wait_for(1, 3);
		end
		// Pseudo stop: periodic timer set to run on, watchdog left to halt.
		do_reset();
		wr(8'h10, 32'h1a);
		wr(8'h0c, 32'h1);
		wr(8'h00, 32'h3);
		wr(8'h08, 32'h2);
		pulse(2);
		d0 = wdr_n;
		wait_for(0, 40);
		repeat (80) @(posedge hclk);
		#1;
		chk("wdt_pstop", d0, wdr_n);
		pulse(3);
		wait_for(1, 40);
		do_reset();
		wr(8'h10, 32'h6);
		pulse(2);
		repeat (20) @(posedge hclk);
		#1;
		chk("fstop", 0, {osc_enable, clk_monitor_enable, sys_clk_release});
		pulse(3);
		wait_for(2, 10);
		chk("pll_sel", 0, pll_clock_select);
		chk("pll_voltage_regulator_unit", 1, pll_voltage_regulator_unit_enable);
		repeat (49) pulse(0);
		chk("early_scm", 0, self_clock_active);
		pulse(0);
		wait_for(3, 4);
		rdc(8'h14, 32'(wdp_pkg::WDP_ST_SCM) << 8 | 32'h1);
		pulse(1);
		wait_for(5, 4);
		do_reset();
		wr(8'h10, 32'h0);
		pulse(2);
		pulse(3);
		d0 = cmr_n;
		repeat (49) pulse(0);
		chk("early_cmr", d0, cmr_n);
		pulse(0);
		chk("cmr", d0 + 1, cmr_n);
		rdc(8'h10, 32'h2);
		chk("held", 0, sys_clk_release);
		pulse(1);
		wait_for(5, 4);
		do_reset();
		wr(8'h10, 32'h3);
		pulse(2);
		pulse(3);
		wait_for(3, 10);
		chk("fast_osc", 0, {osc_enable, clk_monitor_enable});
		rdc(8'h14, 32'(wdp_pkg::WDP_ST_SCM_FAST) << 8);
		wr(8'h10, 32'h2);
		wait_for(2, 5);
		chk("osc_on", 1, osc_enable);
		pulse(1);
		wait_for(5, 5);
		rdc(8'h14, 32'(wdp_pkg::WDP_ST_RUN) << 8 | 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
